/* File: hdl/ifs_filter.sv */
// on/off recognition delay for one terminal
// assumes a level already corrected for contact type and a ms tick
module ifs_filter #(
  parameter int unsigned DW = 14
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          tick,
  input  wire logic          level,
  input  wire logic [DW-1:0] on_delay,
  input  wire logic [DW-1:0] off_delay,
  output logic               state
);

  logic [DW-1:0] cnt_q;
  logic [DW-1:0] cnt_d;
  logic          state_q;
  logic          state_d;
  logic [DW-1:0] limit;
  logic          differ;
  logic          expired;

  // --------------------------------------------------------------
  // delay selection
  // --------------------------------------------------------------
  assign limit   = level ? on_delay : off_delay;       // see R6 see R7
  assign differ  = level != state_q;
  assign expired = cnt_q >= limit;

  // counter restarts whenever the input returns to the held state,
  // so a bounce spanning fewer ms ticks than the delay never reaches the output
  always_comb
  begin
    cnt_d   = cnt_q;
    state_d = state_q;
    if (!differ)
    begin
      cnt_d = '0;
    end
    else if (expired)
    begin
      state_d = level;                                 // see R6 see R7
      cnt_d   = '0;
    end
    else if (tick)
    begin
      cnt_d = cnt_q + 1'b1;                            // see R12
    end
  end

  // state and counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q   <= '0;
      state_q <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  assign state = state_q;

endmodule : ifs_filter

/* File: hdl/ifs_pkg.sv */
// constants for the input filter and source switch block
// assumes one 125 MHz clock and an apb master at the register port
//
// Notes on behaviour
// R1 - alternate terminal selects alternate command, frequency sources
// R2 - terminal function code 15 means alternate-source
// R3 - alternate terminal selects alternate torque source
// R4 - alternate settings locked while primary selection runs
// R5 - torque sources only with sensorless/vector plus torque
// R6 - on recognised after on-delay, 0 to 10000 ms
// R7 - off recognised after off-delay, 0 to 10000 ms
// R8 - each terminal normally open or normally closed
// R9 - contact and status words 8 bits, reset zero
// R10 - status shows on state, inverted for closed contacts
// R11 - controller sets alternate sources before asserting terminal
// R12 - invert contact type first, then ms-tick delay counters
package ifs_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_MS       = 1;          // time base in ms
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_MAX_MS  = 10000;
  localparam int unsigned DELAY_W       = 14;
  localparam logic [13:0] DELAY_MAX     = 14'h2710;   // 10000 ms
  localparam logic [13:0] DELAY_RST     = 14'h0000;

  // ----------------------------------------------------------------
  // terminals and codes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TERM      = 8;
  localparam int unsigned FUNC_W        = 8;
  localparam logic [7:0]  FUNC_ALT_SRC  = 8'h0F;      // code 15
  localparam logic [7:0]  FUNC_RST      = 8'h00;
  localparam int unsigned SRC_W         = 4;
  localparam logic [3:0]  CMD_PRI_RST   = 4'h1;
  localparam logic [3:0]  FREQ_PRI_RST  = 4'h2;
  localparam logic [3:0]  TRQ_PRI_RST   = 4'h0;
  localparam logic [3:0]  CMD_ALT_RST   = 4'h0;
  localparam logic [3:0]  FREQ_ALT_RST  = 4'h0;
  localparam logic [3:0]  TRQ_ALT_RST   = 4'h0;
  localparam logic [7:0]  CONTACT_RST   = 8'h00;

  // control modes; torque sources exist in the last two only
  localparam logic [1:0]  MODE_VF       = 2'h0;
  localparam logic [1:0]  MODE_SLIP     = 2'h1;
  localparam logic [1:0]  MODE_SENSLESS = 2'h2;
  localparam logic [1:0]  MODE_VECTOR   = 2'h3;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CONTACT  = 8'h00;
  localparam logic [7:0]  ADDR_STATE    = 8'h04;
  localparam logic [7:0]  ADDR_ON_DLY   = 8'h08;
  localparam logic [7:0]  ADDR_OFF_DLY  = 8'h0C;
  localparam logic [7:0]  ADDR_FUNC_LO  = 8'h10;      // terminals 1..4
  localparam logic [7:0]  ADDR_FUNC_HI  = 8'h14;      // terminals 5..8
  localparam logic [7:0]  ADDR_PRI_SRC  = 8'h18;
  localparam logic [7:0]  ADDR_ALT_SRC  = 8'h1C;
  localparam logic [7:0]  ADDR_MODE     = 8'h20;
  localparam logic [7:0]  ADDR_TRQ_SRC  = 8'h24;
  localparam logic [7:0]  ADDR_STATUS   = 8'h28;

  // field positions
  localparam int unsigned CMD_LSB       = 0;          // in source regs
  localparam int unsigned FREQ_LSB      = 8;
  localparam int unsigned TRQ_PRI_LSB   = 0;          // in torque reg
  localparam int unsigned TRQ_ALT_LSB   = 8;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned TRQ_EN_BIT    = 4;
  localparam int unsigned ST_ALT_BIT    = 0;
  localparam int unsigned ST_TRQ_BIT    = 1;
  localparam int unsigned ST_RUN_BIT    = 2;

endpackage : ifs_pkg

/* File: hdl/ifs_top.sv */
// terminal conditioning and primary/alternate source switch
// assumes apb3 master on pclk and terminals synchronous to pclk
//
// Local design decisions: the register addresses and register access over APB.
module ifs_top #(
  parameter int unsigned TICK_CYCLES = ifs_pkg::TICK_CYCLES,
  parameter int unsigned NUM_TERM    = ifs_pkg::NUM_TERM
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [NUM_TERM-1:0]        terminal_raw,
  input  wire logic                       drive_running,
  output logic      [NUM_TERM-1:0]        input_terminal_state,
  output logic                            alternate_source_select,
  output logic      [ifs_pkg::SRC_W-1:0]  active_cmd_origin,
  output logic      [ifs_pkg::SRC_W-1:0]  active_freq_origin,
  output logic      [ifs_pkg::SRC_W-1:0]  active_torque_origin,
  output logic                            torque_origin_valid
);

  localparam int unsigned DW = ifs_pkg::DELAY_W;
  localparam int unsigned SW = ifs_pkg::SRC_W;
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  logic [TW-1:0] div_q;
  logic          tick;

  assign tick = div_q == TW'(TICK_CYCLES - 1);

  // one-cycle enable every millisecond for the delay counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= tick ? '0 : div_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0]    contact_q;
  logic [DW-1:0]          on_dly_q;
  logic [DW-1:0]          off_dly_q;
  logic [7:0]             func_q [NUM_TERM];
  logic [SW-1:0]          cmd_pri_q;
  logic [SW-1:0]          freq_pri_q;
  logic [SW-1:0]          cmd_alt_q;
  logic [SW-1:0]          freq_alt_q;
  logic [SW-1:0]          trq_pri_q;
  logic [SW-1:0]          trq_alt_q;
  logic [1:0]             mode_q;
  logic                   trq_en_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        wr;
  logic        hit;
  logic        locked;
  logic        refused;
  logic        trq_avail;
  logic [13:0] wr_delay;
  logic [31:0] rd_mux;
  logic        err_q;
  logic [31:0] rdata_q;

  // saturate delay writes at the top of the legal range
  function automatic logic [13:0] clamp_delay(input logic [31:0] v);
    clamp_delay = (v > 32'(ifs_pkg::DELAY_MAX)) ? ifs_pkg::DELAY_MAX
                                                : v[13:0];
  endfunction : clamp_delay

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr       = access && pwrite && !err_q;
  assign wr_delay = clamp_delay(pwdata);
  assign hit      = paddr == ifs_pkg::ADDR_CONTACT
                 || paddr == ifs_pkg::ADDR_STATE
                 || paddr == ifs_pkg::ADDR_ON_DLY
                 || paddr == ifs_pkg::ADDR_OFF_DLY
                 || paddr == ifs_pkg::ADDR_FUNC_LO
                 || paddr == ifs_pkg::ADDR_FUNC_HI
                 || paddr == ifs_pkg::ADDR_PRI_SRC
                 || paddr == ifs_pkg::ADDR_ALT_SRC
                 || paddr == ifs_pkg::ADDR_MODE
                 || paddr == ifs_pkg::ADDR_TRQ_SRC
                 || paddr == ifs_pkg::ADDR_STATUS;
  // alternate settings frozen while running on the primary set
  assign locked   = drive_running && !alternate_source_select; // see R4
  assign trq_avail = trq_en_q && (mode_q == ifs_pkg::MODE_SENSLESS
                               || mode_q == ifs_pkg::MODE_VECTOR); // see R5
  assign refused  = pwrite && ((paddr == ifs_pkg::ADDR_ALT_SRC && locked)
                 || (paddr == ifs_pkg::ADDR_TRQ_SRC
                     && (!trq_avail || locked)))                 // see R4
                 || (pwrite && paddr == ifs_pkg::ADDR_STATE)
                 || (pwrite && paddr == ifs_pkg::ADDR_STATUS);

  // read mux; torque sources read as zero when not available
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ifs_pkg::ADDR_CONTACT: rd_mux[NUM_TERM-1:0] = contact_q;
      ifs_pkg::ADDR_STATE:   rd_mux[NUM_TERM-1:0] = input_terminal_state;
      ifs_pkg::ADDR_ON_DLY:  rd_mux[DW-1:0] = on_dly_q;
      ifs_pkg::ADDR_OFF_DLY: rd_mux[DW-1:0] = off_dly_q;
      ifs_pkg::ADDR_FUNC_LO: rd_mux = {func_q[3], func_q[2],
                                       func_q[1], func_q[0]};
      ifs_pkg::ADDR_FUNC_HI: rd_mux = {func_q[7], func_q[6],
                                       func_q[5], func_q[4]};
      ifs_pkg::ADDR_PRI_SRC:
      begin
        rd_mux[ifs_pkg::CMD_LSB +: SW]  = cmd_pri_q;
        rd_mux[ifs_pkg::FREQ_LSB +: SW] = freq_pri_q;
      end
      ifs_pkg::ADDR_ALT_SRC:
      begin
        rd_mux[ifs_pkg::CMD_LSB +: SW]  = cmd_alt_q;
        rd_mux[ifs_pkg::FREQ_LSB +: SW] = freq_alt_q;
      end
      ifs_pkg::ADDR_MODE:
      begin
        rd_mux[ifs_pkg::MODE_LSB +: 2]  = mode_q;
        rd_mux[ifs_pkg::TRQ_EN_BIT]     = trq_en_q;
      end
      ifs_pkg::ADDR_TRQ_SRC:
      begin
        if (trq_avail)                                           // see R5
        begin
          rd_mux[ifs_pkg::TRQ_PRI_LSB +: SW] = trq_pri_q;
          rd_mux[ifs_pkg::TRQ_ALT_LSB +: SW] = trq_alt_q;
        end
      end
      ifs_pkg::ADDR_STATUS:
      begin
        rd_mux[ifs_pkg::ST_ALT_BIT] = alternate_source_select;
        rd_mux[ifs_pkg::ST_TRQ_BIT] = trq_avail;
        rd_mux[ifs_pkg::ST_RUN_BIT] = drive_running;
      end
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // answer prepared in the setup cycle so prdata comes from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      err_q   <= !hit || refused;
    end
  end

  assign pready  = 1'b1;                 // zero wait states
  assign pslverr = access && err_q;
  assign prdata  = rdata_q;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // writes land at the access edge; refused ones change nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      contact_q  <= ifs_pkg::CONTACT_RST;                        // see R9
      on_dly_q   <= ifs_pkg::DELAY_RST;                          // see R6
      off_dly_q  <= ifs_pkg::DELAY_RST;                          // see R7
      cmd_pri_q  <= ifs_pkg::CMD_PRI_RST;
      freq_pri_q <= ifs_pkg::FREQ_PRI_RST;
      cmd_alt_q  <= ifs_pkg::CMD_ALT_RST;
      freq_alt_q <= ifs_pkg::FREQ_ALT_RST;
      trq_pri_q  <= ifs_pkg::TRQ_PRI_RST;
      trq_alt_q  <= ifs_pkg::TRQ_ALT_RST;
      mode_q     <= ifs_pkg::MODE_VF;
      trq_en_q   <= 1'b0;
    end
    else if (wr)
    begin
      unique case (paddr)
        ifs_pkg::ADDR_CONTACT: contact_q <= pwdata[NUM_TERM-1:0]; // see R8
        ifs_pkg::ADDR_ON_DLY:  on_dly_q  <= wr_delay;
        ifs_pkg::ADDR_OFF_DLY: off_dly_q <= wr_delay;
        ifs_pkg::ADDR_PRI_SRC:
        begin
          cmd_pri_q  <= pwdata[ifs_pkg::CMD_LSB +: SW];
          freq_pri_q <= pwdata[ifs_pkg::FREQ_LSB +: SW];
        end
        ifs_pkg::ADDR_ALT_SRC:
        begin
          cmd_alt_q  <= pwdata[ifs_pkg::CMD_LSB +: SW];
          freq_alt_q <= pwdata[ifs_pkg::FREQ_LSB +: SW];
        end
        ifs_pkg::ADDR_MODE:
        begin
          mode_q   <= pwdata[ifs_pkg::MODE_LSB +: 2];
          trq_en_q <= pwdata[ifs_pkg::TRQ_EN_BIT];
        end
        ifs_pkg::ADDR_TRQ_SRC:
        begin
          trq_pri_q <= pwdata[ifs_pkg::TRQ_PRI_LSB +: SW];
          trq_alt_q <= pwdata[ifs_pkg::TRQ_ALT_LSB +: SW];
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-terminal function code, contact fix-up and filter
  // ----------------------------------------------------------------
  logic [NUM_TERM-1:0] level;
  logic [NUM_TERM-1:0] alt_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++)
    begin : g_term
      localparam logic [7:0] FADDR = (gi < 4) ? ifs_pkg::ADDR_FUNC_LO
                                              : ifs_pkg::ADDR_FUNC_HI;
      localparam int unsigned FLSB = (gi % 4) * 8;

      // function code byte for this terminal
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          func_q[gi] <= ifs_pkg::FUNC_RST;
        end
        else if (wr && paddr == FADDR)
        begin
          func_q[gi] <= pwdata[FLSB +: 8];                       // see R2
        end
      end

      // closed contact reads active when the raw line is low
      assign level[gi] = terminal_raw[gi] ^ contact_q[gi]; // see R10 see R12

      ifs_filter #(
        .DW (DW)
      ) u_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .level     (level[gi]),
        .on_delay  (on_dly_q),
        .off_delay (off_dly_q),
        .state     (input_terminal_state[gi])
      );

      assign alt_hit[gi] = input_terminal_state[gi]
                        && func_q[gi] == ifs_pkg::FUNC_ALT_SRC;  // see R2
    end
  endgenerate

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // switch is immediate, the controller must preload the alternates
  assign alternate_source_select = |alt_hit;
  assign active_cmd_origin  = alternate_source_select ? cmd_alt_q
                                                      : cmd_pri_q;  // see R1
  assign active_freq_origin = alternate_source_select ? freq_alt_q
                                                      : freq_pri_q; // see R1
  assign active_torque_origin = !trq_avail ? '0
                              : alternate_source_select ? trq_alt_q
                                                        : trq_pri_q; // see R3
  assign torque_origin_valid = trq_avail;                          // see R5

endmodule : ifs_top

/* File: verif/ifs_checker.sv */
// concurrent checks on the source switch ports
// assumes a single pclk domain and presetn as its reset
module ifs_checker #(
  parameter int unsigned NUM_TERM = 8
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_TERM-1:0] terminal_raw,
  input wire logic                drive_running,
  input wire logic [NUM_TERM-1:0] input_terminal_state,
  input wire logic                alternate_source_select,
  input wire logic [3:0]          active_cmd_origin,
  input wire logic [3:0]          active_freq_origin,
  input wire logic [3:0]          active_torque_origin,
  input wire logic                torque_origin_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // shadow of settings, moved by accepted writes only
  // ------------------------------------------------------------
  logic        wr_ok;
  logic [11:0] pri_q, alt_q, trq_q;
  logic [7:0]  cont_q, lvl_q, sel_m;
  logic [63:0] fn_q;
  assign wr_ok = psel && penable && pwrite && pready && !pslverr;
  for (genvar i = 0; i < 8; i++)
  begin : g_sel
    assign sel_m[i] = fn_q[8*i +: 8] == ifs_pkg::FUNC_ALT_SRC;
  end
  // refused writes change neither shadow nor design
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pri_q  <= 12'h201;
      alt_q  <= 12'h000;
      trq_q  <= 12'h000;
      cont_q <= 8'h00;
      fn_q   <= 64'h0;
    end
    else if (wr_ok)
    begin
      case (paddr)
        ifs_pkg::ADDR_CONTACT: cont_q <= pwdata[7:0];
        ifs_pkg::ADDR_FUNC_LO: fn_q[31:0] <= pwdata;
        ifs_pkg::ADDR_FUNC_HI: fn_q[63:32] <= pwdata;
        ifs_pkg::ADDR_PRI_SRC: pri_q <= pwdata[11:0];
        ifs_pkg::ADDR_ALT_SRC: alt_q <= pwdata[11:0];
        ifs_pkg::ADDR_TRQ_SRC: trq_q <= pwdata[11:0];
        default: ;
      endcase
    end
  end
  // contact-corrected level as the filter flop sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lvl_q <= 8'h00;
    else
      lvl_q <= terminal_raw ^ cont_q;
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_pri_route: assert property (!alternate_source_select |->
    active_cmd_origin == pri_q[3:0] && active_freq_origin == pri_q[11:8])
    else $error("primary route");
  chk_alt_route: assert property (alternate_source_select |->
    active_cmd_origin == alt_q[3:0] && active_freq_origin == alt_q[11:8])
    else $error("alternate route");
  chk_alt_function: assert property (
    alternate_source_select == |(input_terminal_state & sel_m))
    else $error("alternate select mismatch");
  chk_alt_lock: assert property (psel && !penable && pwrite &&
    paddr == ifs_pkg::ADDR_ALT_SRC && drive_running &&
    !alternate_source_select |=> pslverr)
    else $error("locked write accepted");
  chk_torque_gate: assert property (
    !torque_origin_valid |-> active_torque_origin == 4'h0)
    else $error("torque shown unavailable");
  chk_torque_route: assert property (torque_origin_valid |->
    active_torque_origin == (alternate_source_select ? trq_q[11:8]
                                                     : trq_q[3:0]))
    else $error("torque route");
  chk_state_reset: assert property (
    $rose(presetn) |-> input_terminal_state == 8'h00)
    else $error("state not reset");
  chk_on_level: assert property ((input_terminal_state &
    ~$past(input_terminal_state) & ~($past(lvl_q) | lvl_q)) == 8'h00)
    else $error("on without level");
  chk_off_level: assert property ((~input_terminal_state &
    $past(input_terminal_state) & $past(lvl_q) & lvl_q) == 8'h00)
    else $error("off without level");
  cov_alt: cover property (alternate_source_select);
  cov_refused: cover property (psel && penable && pslverr);
  cov_alt_torque: cover property (torque_origin_valid &&
    alternate_source_select);
endmodule : ifs_checker

bind ifs_top ifs_checker #(
  .NUM_TERM(NUM_TERM)
) i_ifs_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .terminal_raw(terminal_raw),
  .drive_running(drive_running),
  .input_terminal_state(input_terminal_state),
  .alternate_source_select(alternate_source_select),
  .active_cmd_origin(active_cmd_origin),
  .active_freq_origin(active_freq_origin),
  .active_torque_origin(active_torque_origin),
  .torque_origin_valid(torque_origin_valid)
);

/* File: verif/ifs_contact_model.sv */
// switch contact model for the eight input terminals
// assumes the bench presses contacts just after a clock edge
module ifs_contact_model #(
  parameter int unsigned N = 8
) (
  input  wire logic [N-1:0] closed_type,
  input  wire logic [N-1:0] pressed,
  output logic      [N-1:0] terminal_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // a closed-type contact conducts at rest and opens when pressed
  assign terminal_raw = pressed ^ closed_type;
endmodule : ifs_contact_model

/* File: verif/testbench.sv */
// self-checking bench for the filter and source switch
// assumes a 10-cycle ms tick so that delays stay short
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        drive_running, alt_sel, trq_valid, err;
  logic [7:0]  paddr, closed_type, pressed, terminal_raw, st;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  cmd_o, freq_o, trq_o;
  int          failures, check_count;
  ifs_top #(.TICK_CYCLES(10), .NUM_TERM(8)) i_ifs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .terminal_raw(terminal_raw),
    .drive_running(drive_running), .input_terminal_state(st),
    .alternate_source_select(alt_sel), .active_cmd_origin(cmd_o),
    .active_freq_origin(freq_o), .active_torque_origin(trq_o),
    .torque_origin_valid(trq_valid));
  ifs_contact_model #(.N(8)) i_ifs_contact_model (
    .closed_type(closed_type), .pressed(pressed),
    .terminal_raw(terminal_raw));
  // ------------------------------------------------------------
  // clock, shared tasks
  // ------------------------------------------------------------
  always #4 pclk = ~pclk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer; waits for pready, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e);
    apb(1'b1, a, d);
    check(32'(err), 32'(e));
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  // bounded wait for one terminal to settle
  task automatic wait_bit(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (st[i] !== v && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(st[i]), 32'(v));
  endtask : wait_bit
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    check(32'({cmd_o, freq_o, trq_o}), 32'h0000_0120);
    rdchk(ifs_pkg::ADDR_CONTACT, 32'h0000_0000);
    rdchk(ifs_pkg::ADDR_STATE, 32'h0000_0000);
    rdchk(8'h3C, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
  endtask : t_reset
  task automatic t_contact;
    closed_type <= 8'hA5;
    wr(ifs_pkg::ADDR_CONTACT, 32'h0000_00A5, 1'b0);
    rdchk(ifs_pkg::ADDR_CONTACT, 32'h0000_00A5);
    wr(ifs_pkg::ADDR_STATE, 32'h0000_00FF, 1'b1);
    check(32'(st), 32'h0000_0000);
    pressed <= 8'h81;
    repeat (3) @(posedge pclk);
    check(32'(st), 32'h0000_0081);
    rdchk(ifs_pkg::ADDR_STATE, 32'h0000_0081);
    pressed <= 8'h00;
    closed_type <= 8'h00;
    wr(ifs_pkg::ADDR_CONTACT, 32'h0000_0000, 1'b0);
  endtask : t_contact
  // glitches shorter than the delay must not pass
  task automatic t_delay;
    wr(ifs_pkg::ADDR_ON_DLY, 32'h0000_0003, 1'b0);
    wr(ifs_pkg::ADDR_OFF_DLY, 32'h0000_0002, 1'b0);
    pressed <= 8'h02;
    repeat (15) @(posedge pclk);
    check(32'(st[1]), 32'h0000_0000);
    wait_bit(1, 1'b1, 20);
    pressed <= 8'h00;
    repeat (5) @(posedge pclk);
    pressed <= 8'h02;
    repeat (20) @(posedge pclk);
    check(32'(st[1]), 32'h0000_0001);
    pressed <= 8'h00;
    repeat (8) @(posedge pclk);
    check(32'(st[1]), 32'h0000_0001);
    wait_bit(1, 1'b0, 16);
    wr(ifs_pkg::ADDR_OFF_DLY, 32'h0000_3FFF, 1'b0);
    rdchk(ifs_pkg::ADDR_OFF_DLY, 32'h0000_2710);
    wr(ifs_pkg::ADDR_ON_DLY, 32'h0000_0000, 1'b0);
    wr(ifs_pkg::ADDR_OFF_DLY, 32'h0000_0000, 1'b0);
  endtask : t_delay
  // alternates are set before any terminal asks
  task automatic t_alt;
    logic [63:0] fn;
    wr(ifs_pkg::ADDR_ALT_SRC, 32'h0000_0503, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      fn = 64'h0;
      fn[8*i +: 8] = ifs_pkg::FUNC_ALT_SRC;
      wr(ifs_pkg::ADDR_FUNC_LO, fn[31:0], 1'b0);
      wr(ifs_pkg::ADDR_FUNC_HI, fn[63:32], 1'b0);
      pressed <= 8'(1 << i);
      repeat (3) @(posedge pclk);
      check(32'({alt_sel, cmd_o, freq_o}), 32'h0000_0135);
      pressed <= 8'h00;
      repeat (3) @(posedge pclk);
      check(32'({alt_sel, cmd_o, freq_o}), 32'h0000_0012);
    end
  endtask : t_alt
  task automatic t_lock;
    drive_running <= 1'b1;
    wr(ifs_pkg::ADDR_ALT_SRC, 32'h0000_0707, 1'b1);
    rdchk(ifs_pkg::ADDR_ALT_SRC, 32'h0000_0503);
    pressed <= 8'h80;
    repeat (3) @(posedge pclk);
    wr(ifs_pkg::ADDR_ALT_SRC, 32'h0000_0604, 1'b0);
    check(32'({cmd_o, freq_o}), 32'h0000_0046);
    pressed <= 8'h00;
    drive_running <= 1'b0;
    @(posedge pclk);
  endtask : t_lock
  task automatic t_torque;
    for (int m = 0; m < 4; m++)
    begin
      wr(ifs_pkg::ADDR_MODE, 32'h0000_0010 | 32'(m), 1'b0);
      check(32'(trq_valid), 32'(m >= 2));
      wr(ifs_pkg::ADDR_TRQ_SRC, 32'h0000_0704, m < 2);
    end
    check(32'(trq_o), 32'h0000_0004);
    pressed <= 8'h80;
    repeat (3) @(posedge pclk);
    check(32'(trq_o), 32'h0000_0007);
    pressed <= 8'h00;
    wr(ifs_pkg::ADDR_MODE, 32'h0000_0003, 1'b0);
    check(32'({trq_valid, trq_o}), 32'h0000_0000);
  endtask : t_torque
  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic print_verdict;
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // the whole run needs about 270 cycles
  initial
  begin
    repeat (6000) @(posedge pclk);
    failures++;
    print_verdict();
  end
  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    closed_type = 8'h00; pressed = 8'h00; drive_running = 1'b0;
    failures = 0; check_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_contact();
    t_delay();
    t_alt();
    t_lock();
    t_torque();
    print_verdict();
  end
endmodule : testbench
